// file: hw/dcs_defines.vh
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH
// Object indices of the two process-data words
`define DCS_CMD_WORD_INDEX 16'h6040
`define DCS_STATE_WORD_INDEX 16'h6041
`define DCS_CMD_WORD_RESET 16'h0000
`define DCS_STATE_WORD_RESET 16'h0000
// Command word bit positions
`define DCS_CB_SWITCH_ON 0
`define DCS_CB_ENABLE_VOLTAGE 1
`define DCS_CB_QUICK_STOP 2
`define DCS_CB_ENABLE_OP 3
`define DCS_CB_MODE_4 4
`define DCS_CB_MODE_5 5
`define DCS_CB_FAULT_RESET 7
`define DCS_CB_HALT 8
`define DCS_CB_INPUT_SEVEN 11
`define DCS_CB_INPUT_EIGHT 12
// State word bit positions
`define DCS_SB_VOLTAGE 4
`define DCS_SB_QUICK_STOP 5
`define DCS_SB_SW_DISABLED 6
`define DCS_SB_WARNING 7
`define DCS_SB_UNUSED 8
`define DCS_SB_REMOTE 9
`define DCS_SB_MODE_10 10
`define DCS_SB_LIMIT 11
`define DCS_SB_MODE_12 12
`define DCS_SB_MODE_13 13
`define DCS_SB_OUTPUT_THREE 14
`define DCS_SB_OUTPUT_FOUR 15
// Operation mode codes
`define DCS_MODE_PP 8'h01
`define DCS_MODE_PV 8'h03
`define DCS_MODE_HM 8'h06
`define DCS_MODE_CSP 8'h08
`define DCS_MODE_CSV 8'h09
`define DCS_MODE_CST 8'h0A
// Automaton states
`define DCS_ST_NOT_READY 3'h0
`define DCS_ST_SW_DISABLED 3'h1
`define DCS_ST_READY 3'h2
`define DCS_ST_SWITCHED_ON 3'h3
`define DCS_ST_OP_ENABLED 3'h4
`define DCS_ST_QSTOP 3'h5
`define DCS_ST_FAULT_REACT 3'h6
`define DCS_ST_FAULT 3'h7
// Halt methods
`define DCS_HALT_RAMP 2'h0
`define DCS_HALT_QSTOP_RAMP 2'h1
`define DCS_HALT_TORQUE_LIMIT 2'h2
`endif

// file: hw/dcs_general_io.v
`timescale 1ns/100ps
// One assignable general bit: a function selector picks one of the candidate sources.
module dcs_general_io #(
  parameter SEL_W = 4,
  parameter SRC_N = 16
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [SEL_W-1:0] i_select,
  input wire [SRC_N-1:0] i_sources,
  output reg o_bit
);
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bit <= 1'b0;
    end else if (i_select < SRC_N) begin
      o_bit <= i_sources[i_select];
    end else begin
      // Out-of-range selection leaves the bit inactive
      o_bit <= 1'b0;
    end
  end
endmodule

// file: hw/dcs_state_machine.v
`timescale 1ns/100ps
`include "dcs_defines.vh"
module dcs_state_machine #(
  parameter FUNC_W = 4
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_cmd_write,
  input wire [15:0] i_cmd_word,
  input wire [7:0] i_mode,
  input wire [1:0] i_halt_option,
  input wire i_init_done,
  input wire i_fault,
  input wire i_fault_reaction_done,
  input wire i_quick_stop_done,
  input wire i_main_power,
  input wire i_warning,
  input wire i_remote_allowed,
  input wire i_torque_limit,
  input wire i_overtravel,
  input wire i_target_reached,
  input wire i_following_error,
  input wire i_setpoint_ack,
  input wire i_homing_error,
  input wire i_homing_attained,
  input wire i_speed_zero,
  input wire i_target_followable,
  input wire [FUNC_W-1:0] i_input_seven_function_param,
  input wire [FUNC_W-1:0] i_input_eight_function_param,
  input wire [FUNC_W-1:0] i_output_three_function_param,
  input wire [FUNC_W-1:0] i_output_four_function_param,
  input wire [15:0] i_output_sources,
  output reg [15:0] o_drive_command_word,
  output wire [15:0] o_drive_state_word,
  output reg [2:0] o_drive_state_automaton,
  output reg o_power_stage_on,
  output reg o_operation_enabled,
  output reg o_quick_stop_request,
  output reg o_halt_request,
  output reg [1:0] o_halt_method,
  output reg o_new_setpoint,
  output reg o_change_immediately,
  output reg o_homing_start,
  output reg [15:0] o_command_input_seven_func,
  output reg [15:0] o_command_input_eight_func
);

  ////////////////////////////////////////////////////////////////////////////
  // Command word capture

  reg [15:0] cmd_prev;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] state_word;
  wire general_output_three;
  wire general_output_four;

  wire [15:0] cmd = o_drive_command_word;
  wire b0 = cmd[`DCS_CB_SWITCH_ON];
  wire b1 = cmd[`DCS_CB_ENABLE_VOLTAGE];
  wire b2 = cmd[`DCS_CB_QUICK_STOP];
  wire b3 = cmd[`DCS_CB_ENABLE_OP];
  wire b7 = cmd[`DCS_CB_FAULT_RESET];

  // Reserved bits are stored as written; the controller keeps them zero
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_drive_command_word <= `DCS_CMD_WORD_RESET;
      cmd_prev <= `DCS_CMD_WORD_RESET;
    end else begin
      cmd_prev <= o_drive_command_word;
      if (i_cmd_write) begin
        o_drive_command_word <= i_cmd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire cmd_shutdown = !b7 && b2 && b1 && !b0;
  wire cmd_switch_on = !b7 && !b3 && b2 && b1 && b0;
  wire cmd_enable_op = !b7 && b3 && b2 && b1 && b0;
  wire cmd_quick_stop = !b7 && b3 && !b2 && b1 && b0;
  wire cmd_disable_voltage = !b7 && !b1;
  // Level-held bit 7 would re-arm endlessly, so only the edge counts
  wire cmd_fault_reset = b7 && !cmd_prev[`DCS_CB_FAULT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // Drive state automaton

  always @* begin
    next_state = state;
    case (state)
      `DCS_ST_NOT_READY: begin
        if (i_init_done) begin
          next_state = `DCS_ST_SW_DISABLED;
        end
      end
      `DCS_ST_SW_DISABLED: begin
        if (cmd_shutdown) begin
          next_state = `DCS_ST_READY;
        end
      end
      `DCS_ST_READY: begin
        if (cmd_disable_voltage) begin
          next_state = `DCS_ST_SW_DISABLED;
        end else if (cmd_enable_op) begin
          next_state = `DCS_ST_OP_ENABLED;
        end else if (cmd_switch_on) begin
          next_state = `DCS_ST_SWITCHED_ON;
        end
      end
      `DCS_ST_SWITCHED_ON: begin
        if (cmd_disable_voltage) begin
          next_state = `DCS_ST_SW_DISABLED;
        end else if (cmd_shutdown) begin
          next_state = `DCS_ST_READY;
        end else if (cmd_enable_op) begin
          next_state = `DCS_ST_OP_ENABLED;
        end
      end
      `DCS_ST_OP_ENABLED: begin
        if (cmd_disable_voltage) begin
          next_state = `DCS_ST_SW_DISABLED;
        end else if (cmd_shutdown) begin
          next_state = `DCS_ST_READY;
        end else if (cmd_switch_on) begin
          next_state = `DCS_ST_SWITCHED_ON;
        end else if (cmd_quick_stop) begin
          next_state = `DCS_ST_QSTOP;
        end
      end
      `DCS_ST_QSTOP: begin
        if (cmd_disable_voltage || i_quick_stop_done) begin
          next_state = `DCS_ST_SW_DISABLED;
        end else if (cmd_enable_op) begin
          next_state = `DCS_ST_OP_ENABLED;
        end
      end
      `DCS_ST_FAULT_REACT: begin
        if (i_fault_reaction_done) begin
          next_state = `DCS_ST_FAULT;
        end
      end
      `DCS_ST_FAULT: begin
        // A fault still present blocks the reset
        if (cmd_fault_reset && !i_fault) begin
          next_state = `DCS_ST_SW_DISABLED;
        end
      end
      default: begin
        next_state = `DCS_ST_NOT_READY;
      end
    endcase
    // Fault detection overrides any command outside the fault states and DCS_ST_NOT_READY
    if (i_fault && state != `DCS_ST_FAULT_REACT && state != `DCS_ST_FAULT &&
        state != `DCS_ST_NOT_READY) begin
      next_state = `DCS_ST_FAULT_REACT;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= `DCS_ST_NOT_READY;
      o_drive_state_automaton <= `DCS_ST_NOT_READY;
      o_power_stage_on <= 1'b0;
      o_operation_enabled <= 1'b0;
      o_quick_stop_request <= 1'b0;
    end else begin
      // Outputs decode next_state so they switch on the same edge as the state
      state <= next_state;
      o_drive_state_automaton <= next_state;
      o_power_stage_on <= (next_state == `DCS_ST_SWITCHED_ON) ||
                          (next_state == `DCS_ST_OP_ENABLED) ||
                          (next_state == `DCS_ST_QSTOP) ||
                          (next_state == `DCS_ST_FAULT_REACT);
      o_operation_enabled <= (next_state == `DCS_ST_OP_ENABLED);
      o_quick_stop_request <= (next_state == `DCS_ST_QSTOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Halt and mode-specific command bits

  wire is_pp = (i_mode == `DCS_MODE_PP);
  wire is_hm = (i_mode == `DCS_MODE_HM);
  wire is_pv = (i_mode == `DCS_MODE_PV);
  wire is_csp = (i_mode == `DCS_MODE_CSP);
  wire is_cyclic = is_csp || (i_mode == `DCS_MODE_CSV) || (i_mode == `DCS_MODE_CST);

  // Bit 9 is never looked at
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_halt_request <= 1'b0;
      o_halt_method <= `DCS_HALT_RAMP;
      o_new_setpoint <= 1'b0;
      o_change_immediately <= 1'b0;
      o_homing_start <= 1'b0;
    end else begin
      o_halt_request <= cmd[`DCS_CB_HALT] && o_operation_enabled;
      o_halt_method <= i_halt_option;
      o_new_setpoint <= is_pp && cmd[`DCS_CB_MODE_4];
      o_change_immediately <= is_pp && cmd[`DCS_CB_MODE_5];
      o_homing_start <= is_hm && cmd[`DCS_CB_MODE_4];
    end
  end

  // Each command input drives a one-hot function line picked by its parameter
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_command_input_seven_func <= 16'h0000;
      o_command_input_eight_func <= 16'h0000;
    end else begin
      o_command_input_seven_func <= {15'h0000, cmd[`DCS_CB_INPUT_SEVEN]}
                                    << i_input_seven_function_param;
      o_command_input_eight_func <= {15'h0000, cmd[`DCS_CB_INPUT_EIGHT]}
                                    << i_input_eight_function_param;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State word

  // The selector flop makes bits 14 and 15 trail their source by two edges
  dcs_general_io #(
    .SEL_W(FUNC_W),
    .SRC_N(16)
  ) u_out_three (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_select(i_output_three_function_param),
    .i_sources(i_output_sources),
    .o_bit(general_output_three)
  );

  dcs_general_io #(
    .SEL_W(FUNC_W),
    .SRC_N(16)
  ) u_out_four (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_select(i_output_four_function_param),
    .i_sources(i_output_sources),
    .o_bit(general_output_four)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Automaton pattern

  reg [5:0] fsa_bits;
  reg [15:0] next_state_word;
  reg mode_bit13;
  reg mode_bit12;
  reg mode_bit10;

  // Order of fsa_bits: bit6, bit5, bit3, bit2, bit1, bit0; don't-cares read 0
  always @* begin
    case (state)
      `DCS_ST_NOT_READY: fsa_bits = 6'h00;
      `DCS_ST_SW_DISABLED: fsa_bits = 6'h20;
      `DCS_ST_READY: fsa_bits = 6'h11;
      `DCS_ST_SWITCHED_ON: fsa_bits = 6'h13;
      `DCS_ST_OP_ENABLED: fsa_bits = 6'h17;
      `DCS_ST_QSTOP: fsa_bits = 6'h07;
      `DCS_ST_FAULT_REACT: fsa_bits = 6'h0F;
      `DCS_ST_FAULT: fsa_bits = 6'h08;
      default: fsa_bits = 6'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode-specific status bits

  // Modes outside the table leave bits 13, 12 and 10 at zero
  always @* begin
    mode_bit13 = 1'b0;
    mode_bit12 = 1'b0;
    mode_bit10 = 1'b0;
    if (is_pp) begin
      mode_bit13 = i_following_error;
      mode_bit12 = i_setpoint_ack;
      mode_bit10 = i_target_reached;
    end else if (is_hm) begin
      mode_bit13 = i_homing_error;
      mode_bit12 = i_homing_attained;
      mode_bit10 = i_target_reached;
    end else if (is_pv) begin
      mode_bit12 = i_speed_zero;
    end else if (is_cyclic) begin
      mode_bit13 = is_csp && i_following_error;
      // Zero means the commanded target is not being followed
      mode_bit12 = i_target_followable && o_operation_enabled;
    end
  end

  always @* begin
    next_state_word = `DCS_STATE_WORD_RESET;
    next_state_word[`DCS_SB_SW_DISABLED] = fsa_bits[5];
    next_state_word[`DCS_SB_QUICK_STOP] = fsa_bits[4];
    next_state_word[3:0] = fsa_bits[3:0];
    next_state_word[`DCS_SB_VOLTAGE] = i_main_power;
    next_state_word[`DCS_SB_WARNING] = i_warning;
    // Bit 8 carries nothing and is written zero explicitly
    next_state_word[`DCS_SB_UNUSED] = 1'b0;
    next_state_word[`DCS_SB_REMOTE] = i_remote_allowed;
    next_state_word[`DCS_SB_MODE_10] = mode_bit10;
    next_state_word[`DCS_SB_LIMIT] = i_torque_limit || i_overtravel;
    next_state_word[`DCS_SB_MODE_12] = mode_bit12;
    next_state_word[`DCS_SB_MODE_13] = mode_bit13;
    next_state_word[`DCS_SB_OUTPUT_THREE] = general_output_three;
    next_state_word[`DCS_SB_OUTPUT_FOUR] = general_output_four;
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_word <= `DCS_STATE_WORD_RESET;
    end else begin
      state_word <= next_state_word;
    end
  end

  assign o_drive_state_word = state_word;

endmodule

// file: verif/dcs_sm_properties.sv
`timescale 1ns/100ps
`include "dcs_defines.vh"
module dcs_sm_properties #(
  parameter FUNC_W = 4
) (
  input logic i_clk,
  input logic i_reset_n,
  input logic i_cmd_write,
  input logic [15:0] i_cmd_word,
  input logic [7:0] i_mode,
  input logic i_fault,
  input logic i_main_power,
  input logic i_target_followable,
  input logic [FUNC_W-1:0] i_input_seven_function_param,
  input logic [15:0] o_drive_command_word,
  input logic [15:0] o_drive_state_word,
  input logic [2:0] o_drive_state_automaton,
  input logic [15:0] o_command_input_seven_func
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire [15:0] cw = o_drive_command_word;
  wire [15:0] sw = o_drive_state_word;
  wire [2:0] st = o_drive_state_automaton;
  //////////////////////////////////////////
  property p_cmd_load;
    i_cmd_write |=> cw == $past(i_cmd_word);
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command word not loaded");
  property p_shutdown;
    st == `DCS_ST_SW_DISABLED && !cw[7] && cw[2:0] == 3'h6 && !i_fault |=> st == `DCS_ST_READY;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown ignored");
  property p_enable_direct;
    st == `DCS_ST_READY && !cw[7] && cw[3:0] == 4'hF && !i_fault |=> st == `DCS_ST_OP_ENABLED;
  endproperty
  a_enable_direct: assert property (p_enable_direct) else $error("no direct enable");
  property p_quick_stop;
    st == `DCS_ST_OP_ENABLED && !cw[7] && cw[3:0] == 4'hB && !i_fault |=> st == `DCS_ST_QSTOP;
  endproperty
  a_quick_stop: assert property (p_quick_stop) else $error("quick stop ignored");
  property p_fault_edge;
    st == `DCS_ST_FAULT && !(cw[7] && !$past(cw[7])) |=> st == `DCS_ST_FAULT;
  endproperty
  a_fault_edge: assert property (p_fault_edge) else $error("fault left without edge");
  property p_fsa_op;
    st == `DCS_ST_OP_ENABLED |=> {sw[6:5], sw[3:0]} == 6'h17;
  endproperty
  a_fsa_op: assert property (p_fsa_op) else $error("enabled pattern wrong");
  property p_power_bit;
    $past(i_reset_n) && $stable(i_main_power) |=> sw[4] == $past(i_main_power);
  endproperty
  a_power_bit: assert property (p_power_bit) else $error("power bit wrong");
  property p_target_ignored;
    i_mode == `DCS_MODE_CSP && $stable(i_mode) && !i_target_followable
      && $stable(i_target_followable) |=> !sw[12];
  endproperty
  a_target_ignored: assert property (p_target_ignored) else $error("ignored bit set");
  property p_input_func;
    $past(i_reset_n) && !i_cmd_write && $stable(cw)
      |=> o_command_input_seven_func ==
        ({15'h0, $past(cw[11])} << $past(i_input_seven_function_param));
  endproperty
  a_input_func: assert property (p_input_func) else $error("input function wrong");
endmodule
bind dcs_state_machine dcs_sm_properties #(.FUNC_W(FUNC_W)) u_props (
  .i_clk, .i_reset_n, .i_cmd_write, .i_cmd_word, .i_mode, .i_fault, .i_main_power,
  .i_target_followable, .i_input_seven_function_param, .o_drive_command_word,
  .o_drive_state_word, .o_drive_state_automaton, .o_command_input_seven_func
);

// file: verif/dcs_net_master.sv
`timescale 1ns/100ps
module dcs_net_master (
  input wire logic i_clk,
  output logic o_cmd_write,
  output logic [15:0] o_cmd_word
);
  initial begin
    o_cmd_write = 1'h0;
    o_cmd_word = 16'h0000;
  end
  //////////////////////////////////////////
  // Gap lets a caller play a slow controller
  task send(input logic [15:0] w, input int gap);
    repeat (gap + 1) @(posedge i_clk);
    #1;
    o_cmd_word = w & 16'h1BFF;
    o_cmd_write = 1'h1;
    @(posedge i_clk);
    #1;
    o_cmd_write = 1'h0;
    // Stale word is scrambled so nothing can lean on it
    o_cmd_word = ~o_cmd_word;
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
`include "dcs_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
  logic i_clk, i_reset_n, i_init_done, i_fault, i_fault_reaction_done, i_quick_stop_done;
  logic i_main_power, i_warning, i_remote_allowed, i_torque_limit, i_overtravel;
  logic i_target_reached, i_following_error, i_setpoint_ack, i_homing_error;
  logic i_homing_attained, i_speed_zero, i_target_followable, i_cmd_write;
  logic [7:0] i_mode;
  logic [1:0] i_halt_option, o_halt_method;
  logic [3:0] i_input_seven_function_param, i_input_eight_function_param;
  logic [3:0] i_output_three_function_param, i_output_four_function_param;
  logic [15:0] i_output_sources, i_cmd_word, o_drive_command_word, o_drive_state_word;
  logic [15:0] o_command_input_seven_func, o_command_input_eight_func;
  logic [2:0] o_drive_state_automaton;
  logic o_power_stage_on, o_operation_enabled, o_quick_stop_request, o_halt_request;
  logic o_new_setpoint, o_change_immediately, o_homing_start;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  wire [15:0] sw = o_drive_state_word;
  wire [2:0] st = o_drive_state_automaton;
  wire [2:0] mb = {o_new_setpoint, o_change_immediately, o_homing_start};
  wire [2:0] pw = {o_power_stage_on, o_operation_enabled, o_quick_stop_request};
  dcs_state_machine u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_write(i_cmd_write), .i_cmd_word(i_cmd_word),
    .i_mode(i_mode), .i_halt_option(i_halt_option), .i_init_done(i_init_done), .i_fault(i_fault),
    .i_fault_reaction_done(i_fault_reaction_done), .i_quick_stop_done(i_quick_stop_done),
    .i_main_power(i_main_power), .i_warning(i_warning), .i_remote_allowed(i_remote_allowed),
    .i_torque_limit(i_torque_limit), .i_overtravel(i_overtravel),
    .i_target_reached(i_target_reached), .i_following_error(i_following_error),
    .i_setpoint_ack(i_setpoint_ack), .i_homing_error(i_homing_error),
    .i_homing_attained(i_homing_attained), .i_speed_zero(i_speed_zero),
    .i_target_followable(i_target_followable),
    .i_input_seven_function_param(i_input_seven_function_param),
    .i_input_eight_function_param(i_input_eight_function_param),
    .i_output_three_function_param(i_output_three_function_param),
    .i_output_four_function_param(i_output_four_function_param),
    .i_output_sources(i_output_sources), .o_drive_command_word(o_drive_command_word),
    .o_drive_state_word(o_drive_state_word), .o_drive_state_automaton(o_drive_state_automaton),
    .o_power_stage_on(o_power_stage_on), .o_operation_enabled(o_operation_enabled),
    .o_quick_stop_request(o_quick_stop_request), .o_halt_request(o_halt_request),
    .o_halt_method(o_halt_method), .o_new_setpoint(o_new_setpoint),
    .o_change_immediately(o_change_immediately), .o_homing_start(o_homing_start),
    .o_command_input_seven_func(o_command_input_seven_func),
    .o_command_input_eight_func(o_command_input_eight_func)
  );
  dcs_net_master u_net (.i_clk(i_clk), .o_cmd_write(i_cmd_write), .o_cmd_word(i_cmd_word));
  initial begin
    {i_clk, i_reset_n, i_init_done, i_fault, i_fault_reaction_done, i_quick_stop_done} = '0;
    {i_main_power, i_warning, i_remote_allowed, i_torque_limit, i_overtravel} = '0;
    {i_target_reached, i_following_error, i_setpoint_ack, i_homing_error} = '0;
    {i_homing_attained, i_speed_zero, i_target_followable, i_halt_option} = '0;
    {i_input_seven_function_param, i_input_eight_function_param} = '0;
    {i_output_three_function_param, i_output_four_function_param, i_output_sources} = '0;
    i_mode = `DCS_MODE_PP;
    forever #5 i_clk = ~i_clk;
  end
  //////////////////////////////////////////
  task complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  task wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task go(input logic [15:0] w, input logic [2:0] e);
    u_net.send(w, 0);
    wt(3);
    `CHK(st, e)
  endtask
  task t_walk();
    `CHK({o_drive_command_word, sw, st}, 35'h0)
    i_init_done = 1'h1;
    wt(3);
    `CHK({sw[6], sw[3:0]}, 5'h10)
    go(16'h000F, `DCS_ST_SW_DISABLED);
    go(16'h0006, `DCS_ST_READY);
    `CHK({sw[6:5], sw[3:0]}, 6'h11)
    go(16'h000F, `DCS_ST_OP_ENABLED);
    `CHK(pw, 3'h6)
    go(16'h020F, `DCS_ST_OP_ENABLED);
    go(16'h000B, `DCS_ST_QSTOP);
    `CHK({sw[6:5], sw[3:0]}, 6'h07)
    `CHK(pw, 3'h5)
    i_quick_stop_done = 1'h1;
    go(16'h000B, `DCS_ST_SW_DISABLED);
    i_quick_stop_done = 1'h0;
    go(16'h0006, `DCS_ST_READY);
    go(16'h0007, `DCS_ST_SWITCHED_ON);
    `CHK({sw[6:5], sw[3:0]}, 6'h13)
    `CHK(pw, 3'h4)
    go(16'h0005, `DCS_ST_SW_DISABLED);
    `CHK(pw, 3'h0)
    $display("walk test done");
  endtask
  task t_fault();
    i_fault = 1'h1;
    wt(3);
    `CHK({st, sw[6], sw[3:0]}, {`DCS_ST_FAULT_REACT, 5'h0F})
    `CHK(pw, 3'h4)
    i_fault_reaction_done = 1'h1;
    go(16'h0080, `DCS_ST_FAULT);
    `CHK({sw[6], sw[3:0]}, 5'h08)
    {i_fault, i_fault_reaction_done} = 2'h0;
    go(16'h0080, `DCS_ST_FAULT);
    go(16'h0000, `DCS_ST_FAULT);
    go(16'h008F, `DCS_ST_SW_DISABLED);
    $display("fault test done");
  endtask
  task t_status();
    {i_main_power, i_warning, i_remote_allowed, i_torque_limit} = 4'hF;
    wt(3);
    `CHK({sw[11], sw[9:7], sw[4]}, 5'h1B)
    {i_warning, i_remote_allowed, i_torque_limit, i_overtravel} = 4'h1;
    wt(3);
    `CHK({sw[11], sw[9:7], sw[4]}, 5'h11)
    $display("status test done");
  endtask
  task t_mode();
    go(16'h0006, `DCS_ST_READY);
    go(16'h003F, `DCS_ST_OP_ENABLED);
    `CHK(mb, 3'h6)
    {i_following_error, i_setpoint_ack, i_target_reached, i_homing_error} = 4'hF;
    wt(3);
    `CHK({sw[13:12], sw[10]}, 3'h7)
    i_mode = `DCS_MODE_HM;
    wt(3);
    `CHK({mb, sw[13:12], sw[10]}, 6'h0D)
    i_mode = `DCS_MODE_CSP;
    i_target_followable = 1'h1;
    wt(3);
    `CHK({mb, sw[13:12], sw[10]}, 6'h06)
    i_target_followable = 1'h0;
    wt(3);
    `CHK({mb, sw[13:12], sw[10]}, 6'h04)
    {i_mode, i_target_followable} = {`DCS_MODE_CSV, 1'h1};
    wt(3);
    `CHK({mb, sw[13:12], sw[10]}, 6'h02)
    {i_mode, i_target_followable} = {`DCS_MODE_CST, 1'h0};
    wt(3);
    `CHK({mb, sw[13:12], sw[10]}, 6'h00)
    i_mode = `DCS_MODE_PV;
    i_speed_zero = 1'h1;
    wt(3);
    `CHK({mb, sw[13:12], sw[10]}, 6'h02)
    $display("mode test done");
  endtask
  task t_gen();
    i_halt_option = `DCS_HALT_TORQUE_LIMIT;
    {i_input_seven_function_param, i_input_eight_function_param} = 8'h35;
    go(16'h190F, `DCS_ST_OP_ENABLED);
    `CHK({o_halt_request, o_halt_method}, 3'h6)
    `CHK({o_command_input_seven_func, o_command_input_eight_func}, 32'h00080020)
    {i_output_three_function_param, i_output_four_function_param} = 8'h23;
    i_output_sources = 16'h0024;
    wt(3);
    `CHK(sw[15:14], 2'h1)
    $display("general io test done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_reset_n = 1'h1;
    t_walk();
    t_fault();
    t_status();
    t_mode();
    t_gen();
    complete_run();
  end
endmodule
